//--- rtl/i2c_line_sync.v
/*
 * Two-flop synchronisers for SCL and SDA with edge, start and stop detection.
 * Assumes both lines are asynchronous to sys_clk_i and slow against it.
 */
`timescale 1ns/1ns
module i2c_line_sync (
    input  wire sys_clk_i,
    input  wire reset_i,
    input  wire scl_i,
    input  wire sda_i,
    output wire scl_o,
    output wire sda_o,
    output wire scl_rise_o,
    output wire scl_fall_o,
    output wire start_o,
    output wire stop_o
);
    reg [1:0] meta;
    reg [1:0] sync;
    reg [1:0] last;
    wire [1:0] raw = {sda_i, scl_i};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : line
            always @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    meta[g] <= 1'b1;
                    sync[g] <= 1'b1;
                    last[g] <= 1'b1;
                end else begin
                    meta[g] <= raw[g];
                    sync[g] <= meta[g];
                    last[g] <= sync[g];
                end
            end
        end
    endgenerate

    assign scl_o      = sync[0];
    assign sda_o      = sync[1];
    assign scl_rise_o = sync[0] & ~last[0];
    assign scl_fall_o = ~sync[0] & last[0];
    // SDA may only move while SCL is high at a start or a stop.
    assign start_o    = sync[0] & last[0] & ~sync[1] & last[1];
    assign stop_o     = sync[0] & last[0] & sync[1] & ~last[1];
endmodule

//--- rtl/i2c_register_window.v
/*
 * I2C target exposing an 8-bit peripheral address space with mailboxes and
 * windows that bridge bytes onto the internal register bus.
 * Assumes the internal bus takes a write pulse at once and answers a read
 * pulse with bus_rd_done_i; host inputs are on sys_clk_i.
 */
`timescale 1ns/1ns
`include "i2c_window_consts.vh"
module i2c_register_window (
    input  wire        sys_clk_i,
    input  wire        reset_i,
    input  wire        scl_i,
    output reg         scl_o,
    output reg         scl_oe_n_o,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_n_o,
    input  wire [6:0]  target_address_field_i,
    input  wire        rd_en_i,
    input  wire        wr_en_i,
    input  wire [2:0]  flag_clear_i,
    input  wire [2:0]  flag_enable_i,
    input  wire [31:0] outgoing_mailbox_i,
    input  wire [31:0] status_summary_i,
    output reg  [31:0] incoming_mailbox_o,
    output reg  [7:0]  pointer_view_field_o,
    output reg  [2:0]  flags_o,
    output reg         irq_o,
    output reg         bus_wr_o,
    output reg         bus_rd_o,
    output reg  [31:0] bus_addr_o,
    output reg  [31:0] bus_wdata_o,
    input  wire [31:0] bus_rdata_i,
    input  wire        bus_rd_done_i
);
    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_ADDR = 8'h02;
    localparam [7:0] S_AACK = 8'h04;
    localparam [7:0] S_RX   = 8'h08;
    localparam [7:0] S_WACK = 8'h10;
    localparam [7:0] S_HOLD = 8'h20;
    localparam [7:0] S_TX   = 8'h40;
    localparam [7:0] S_RACK = 8'h80;

    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;

    i2c_line_sync line_sync (
        .sys_clk_i  (sys_clk_i),
        .reset_i    (reset_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .scl_o      (scl_s),
        .sda_o      (sda_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_seen),
        .stop_o     (stop_seen)
    );

    reg [7:0]  state;
    reg [3:0]  bit_cnt;
    reg [7:0]  shift;
    reg        read_dir;
    reg        first_byte;
    reg        master_ack;
    reg        in_txn;
    reg        txn_wrote;
    reg        txn_read;
    reg [31:0] wr_addr;
    reg [31:0] wr_data;
    reg [31:0] rd_addr;
    reg [31:0] rd_data;
    reg [31:0] acc_ctrl;
    reg [31:0] alert_en;
    reg [2:0]  flag_set;
    reg [2:0]  next_flags;

    wire alert_flag = |(status_summary_i & alert_en);

    // Word that a peripheral address falls in; unmapped space reads zero.
    function [31:0] window_word;
        input [7:0] pa;
        begin
            if (pa[7:2] == `PA_WR_ADDR >> 2)
                window_word = wr_addr;
            else if (pa[7:2] == `PA_WR_DATA >> 2)
                window_word = wr_data;
            else if (pa[7:2] == `PA_RD_ADDR >> 2)
                window_word = rd_addr;
            else if (pa[7:2] == `PA_RD_DATA >> 2)
                window_word = rd_data;
            else if (pa[7:2] == `PA_ACC_STAT >> 2)
                window_word = {31'h0000_0000, alert_flag};
            else if (pa[7:2] == `PA_ACC_CTRL >> 2)
                window_word = acc_ctrl;
            else if (pa[7:2] == `PA_STAT_SUM >> 2)
                window_word = status_summary_i;
            else if (pa[7:2] == `PA_ALERT_EN >> 2)
                window_word = alert_en;
            else if (pa[7:2] == `PA_MBOX_OUT >> 2)
                window_word = outgoing_mailbox_i;
            else if (pa[7:2] == `PA_MBOX_IN >> 2)
                window_word = incoming_mailbox_o;
            else
                window_word = `WORD_RESET;
        end
    endfunction

    // Byte lane 0 is the least significant byte of each word.
    function [7:0] window_byte;
        input [7:0] pa;
        reg [31:0] w;
        begin
            w = window_word(pa);
            window_byte = w[{pa[1:0], 3'b000} +: 8];
        end
    endfunction

    function [7:0] next_read_pa;
        input [7:0] pa;
        begin
            if (pa == `PA_TOP)
                next_read_pa = `PA_RESET;
            else if (pa == `PA_RD_DATA_MSB)
                next_read_pa = `PA_RD_DATA;
            else
                next_read_pa = pa + 8'h01;
        end
    endfunction

    function [7:0] next_write_pa;
        input [7:0] pa;
        begin
            if (pa == `PA_TOP)
                next_write_pa = `PA_RESET;
            else if (pa == `PA_WR_DATA_MSB)
                next_write_pa = `PA_WR_DATA;
            else
                next_write_pa = pa + 8'h01;
        end
    endfunction

    // Byte that the pointer currently selects for a read.
    wire [7:0] cur_byte = window_byte(pointer_view_field_o);

    always @* begin
        flag_set = 3'b000;
        if (stop_seen && in_txn) begin
            flag_set[`FLAG_DONE]  = 1'b1;
            flag_set[`FLAG_WRITE] = txn_wrote;
            flag_set[`FLAG_READ]  = txn_read;
        end
        next_flags = (flags_o & ~flag_clear_i) | flag_set;
    end

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state                <= S_IDLE;
            bit_cnt              <= 4'h0;
            shift                <= 8'h00;
            read_dir             <= 1'b0;
            first_byte           <= 1'b0;
            master_ack           <= 1'b0;
            in_txn               <= 1'b0;
            txn_wrote            <= 1'b0;
            txn_read             <= 1'b0;
            wr_addr              <= `WORD_RESET;
            wr_data              <= `WORD_RESET;
            rd_addr              <= `WORD_RESET;
            rd_data              <= `WORD_RESET;
            acc_ctrl             <= `WORD_RESET;
            alert_en             <= `WORD_RESET;
            incoming_mailbox_o   <= `WORD_RESET;
            pointer_view_field_o <= `PA_RESET;
            flags_o              <= 3'b000;
            irq_o                <= 1'b0;
            scl_o                <= 1'b0;
            scl_oe_n_o           <= 1'b1;
            sda_o                <= 1'b0;
            sda_oe_n_o           <= 1'b1;
            bus_wr_o             <= 1'b0;
            bus_rd_o             <= 1'b0;
            bus_addr_o           <= `WORD_RESET;
            bus_wdata_o          <= `WORD_RESET;
        end else begin
            bus_wr_o <= 1'b0;
            bus_rd_o <= 1'b0;
            flags_o  <= next_flags;
            irq_o    <= |(next_flags & flag_enable_i);
            if (start_seen) begin
                // A start or repeated start always restarts address reception.
                state      <= S_ADDR;
                bit_cnt    <= 4'h0;
                sda_oe_n_o <= 1'b1;
                scl_oe_n_o <= 1'b1;
            end else if (stop_seen) begin
                state      <= S_IDLE;
                in_txn     <= 1'b0;
                txn_wrote  <= 1'b0;
                txn_read   <= 1'b0;
                sda_oe_n_o <= 1'b1;
                scl_oe_n_o <= 1'b1;
            end else begin
                case (state)
                S_ADDR, S_RX: begin
                    if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
                        shift   <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
                        bit_cnt <= 4'h0;
                        if (state == S_ADDR) begin
                            if (shift[7:1] == target_address_field_i) begin
                                read_dir   <= shift[0];
                                in_txn     <= 1'b1;
                                sda_oe_n_o <= 1'b0;
                                state      <= S_AACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end else begin
                            sda_oe_n_o <= 1'b0;
                            state      <= S_WACK;
                            first_byte <= 1'b0;
                            if (first_byte) begin
                                pointer_view_field_o <= shift;
                            end else begin
                                pointer_view_field_o <= next_write_pa(pointer_view_field_o);
                                if (pointer_view_field_o[7:2] == `PA_WR_ADDR >> 2)
                                    wr_addr[{pointer_view_field_o[1:0], 3'b000} +: 8] <= shift;
                                else if (pointer_view_field_o[7:2] == `PA_WR_DATA >> 2)
                                    wr_data[{pointer_view_field_o[1:0], 3'b000} +: 8] <= shift;
                                else if (pointer_view_field_o[7:2] == `PA_RD_ADDR >> 2)
                                    rd_addr[{pointer_view_field_o[1:0], 3'b000} +: 8] <= shift;
                                else if (pointer_view_field_o[7:2] == `PA_ACC_CTRL >> 2)
                                    acc_ctrl[{pointer_view_field_o[1:0], 3'b000} +: 8] <= shift;
                                else if (pointer_view_field_o[7:2] == `PA_ALERT_EN >> 2)
                                    alert_en[{pointer_view_field_o[1:0], 3'b000} +: 8] <= shift;
                                else if (pointer_view_field_o[7:2] == `PA_MBOX_IN >> 2)
                                    incoming_mailbox_o[{pointer_view_field_o[1:0], 3'b000} +: 8]
                                        <= shift;
                                if (pointer_view_field_o == `PA_WR_DATA_MSB && wr_en_i) begin
                                    bus_wr_o    <= 1'b1;
                                    bus_addr_o  <= wr_addr;
                                    bus_wdata_o <= {shift, wr_data[23:0]};
                                    txn_wrote   <= 1'b1;
                                end
                            end
                        end
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        sda_oe_n_o <= 1'b1;
                        state      <= S_RX;
                    end
                end
                S_AACK, S_RACK: begin
                    if (scl_rise)
                        master_ack <= ~sda_s;
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (state == S_AACK && !read_dir) begin
                            sda_oe_n_o <= 1'b1;
                            first_byte <= 1'b1;
                            state      <= S_RX;
                        end else if (state == S_RACK && !master_ack) begin
                            sda_oe_n_o <= 1'b1;
                            state      <= S_IDLE;
                        end else if (pointer_view_field_o == `PA_RD_DATA && rd_en_i) begin
                            sda_oe_n_o <= 1'b1;
                            scl_oe_n_o <= 1'b0;
                            bus_rd_o   <= 1'b1;
                            bus_addr_o <= {rd_addr[31:2], 2'b00};
                            state      <= S_HOLD;
                        end else begin
                            // Reads start at the pointer left behind by earlier traffic.
                            shift                <= cur_byte;
                            sda_oe_n_o           <= cur_byte[7];
                            pointer_view_field_o <= next_read_pa(pointer_view_field_o);
                            state                <= S_TX;
                        end
                    end
                end
                S_HOLD: begin
                    if (bus_rd_done_i) begin
                        rd_data              <= bus_rdata_i;
                        shift                <= bus_rdata_i[7:0];
                        sda_oe_n_o           <= bus_rdata_i[7];
                        pointer_view_field_o <= next_read_pa(pointer_view_field_o);
                        txn_read             <= 1'b1;
                        scl_oe_n_o           <= 1'b1;
                        state                <= S_TX;
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == `LAST_TX_BIT) begin
                            sda_oe_n_o <= 1'b1;
                            state      <= S_RACK;
                        end else begin
                            shift      <= {shift[6:0], 1'b0};
                            sda_oe_n_o <= shift[6];
                            bit_cnt    <= bit_cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
                endcase
            end
        end
    end
endmodule

//--- rtl/i2c_window_consts.vh
/*
 * Constants of the I2C register window target: peripheral offsets,
 * pointer wrap points, reset values, bit counts and flag bit positions.
 * Assumes it is included by bare name from the window design files.
 */
`ifndef I2C_WINDOW_CONSTS_VH
`define I2C_WINDOW_CONSTS_VH

`define PA_WR_ADDR      8'h00
`define PA_WR_DATA      8'h04
`define PA_WR_DATA_MSB  8'h07
`define PA_RD_ADDR      8'h10
`define PA_RD_DATA      8'h14
`define PA_RD_DATA_MSB  8'h17
`define PA_ACC_STAT     8'h20
`define PA_ACC_CTRL     8'h24
`define PA_STAT_SUM     8'h80
`define PA_ALERT_EN     8'h84
`define PA_MBOX_OUT     8'h90
`define PA_MBOX_IN      8'h94
`define PA_TOP          8'hff
`define PA_RESET        8'h00

`define WORD_RESET      32'h0000_0000
`define ALERT_BIT       0
`define BITS_PER_BYTE   4'h8
`define LAST_TX_BIT     4'h7

`define FLAG_DONE       0
`define FLAG_WRITE      1
`define FLAG_READ       2

`endif

//--- test/i2c_master_model.sv
/*
 * Behavioural I2C bus master with start, stop, byte write and byte read.
 * Assumes pull-ups on both wires, resolved outside, and stretches under 5 us.
 */
`timescale 1ns/1ns
module i2c_master_model #(
    parameter int QUARTER = 100
) (
    input  wire logic scl_w_i,
    input  wire logic sda_w_i,
    output logic      scl_rel_o,
    output logic      sda_rel_o,
    output logic      hung_o
);
    initial begin
        scl_rel_o = 1'b1;
        sda_rel_o = 1'b1;
        hung_o = 1'b0;
    end
    // Releases SCL and waits, bounded, while the target stretches it.
    task automatic scl_up();
        scl_rel_o = 1'b1;
        for (int i = 0; i < 500 && !scl_w_i; i++) #10;
        if (!scl_w_i)
            hung_o = 1'b1;
    endtask
    // Serves as start and as repeated start.
    task automatic start();
        #(QUARTER);
        sda_rel_o = 1'b1;
        #(QUARTER);
        scl_up();
        #(QUARTER);
        sda_rel_o = 1'b0;
        #(QUARTER);
        scl_rel_o = 1'b0;
    endtask
    // The long tail lets the target see the stop and update its flags.
    task automatic stop();
        #(QUARTER);
        sda_rel_o = 1'b0;
        #(QUARTER);
        scl_up();
        #(QUARTER);
        sda_rel_o = 1'b1;
        #(4 * QUARTER);
    endtask
    task automatic bit_io(input logic b, output logic r);
        #(QUARTER);
        sda_rel_o = b;
        #(QUARTER);
        scl_up();
        #(QUARTER);
        r = sda_w_i;
        #(QUARTER);
        scl_rel_o = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic more);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!more, r);
    endtask
endmodule

//--- test/i2c_register_window_checker.sv
/*
 * Port checks of the I2C register window: bridge pulses, enables, pointer, stretch.
 * Assumes it is bound to i2c_register_window with host inputs on sys_clk_i.
 */
`timescale 1ns/1ns
module i2c_register_window_checker (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        scl_oe_n_o,
    input wire logic        rd_en_i,
    input wire logic        wr_en_i,
    input wire logic [2:0]  flag_clear_i,
    input wire logic [7:0]  pointer_view_field_o,
    input wire logic [2:0]  flags_o,
    input wire logic        bus_wr_o,
    input wire logic        bus_rd_o,
    input wire logic [31:0] bus_addr_o,
    input wire logic        bus_rd_done_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_wr_one_pulse: assert property (bus_wr_o |=> !bus_wr_o)
        else $error("bridged write pulse too long");
    a_rd_one_pulse: assert property (bus_rd_o |=> !bus_rd_o)
        else $error("bridged read pulse too long");
    a_rd_addr_aligned: assert property (bus_rd_o |-> bus_addr_o[1:0] == 2'b00)
        else $error("bridged read address not aligned");
    a_wr_needs_en: assert property (bus_wr_o |-> wr_en_i)
        else $error("bridged write while disabled");
    a_rd_needs_en: assert property (bus_rd_o |-> rd_en_i)
        else $error("bridged read while disabled");
    a_wr_ptr_back: assert property (bus_wr_o |-> ##[0:2] pointer_view_field_o == 8'h04)
        else $error("pointer not returned after bridged write");
    a_stretch_release: assert property (bus_rd_done_i && !scl_oe_n_o |=> scl_oe_n_o)
        else $error("clock still held after read done");
    a_rd_stretches: assert property (bus_rd_o |-> ##[0:4] (!scl_oe_n_o [*3]))
        else $error("no clock stretch during bridged read");
    a_flags_kept: assert property (~|($past(flags_o) & ~flags_o & ~$past(flag_clear_i)))
        else $error("status flag dropped without clear");
endmodule

bind i2c_register_window i2c_register_window_checker i2c_register_window_checker_i (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_oe_n_o(scl_oe_n_o),
    .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .flag_clear_i(flag_clear_i),
    .pointer_view_field_o(pointer_view_field_o), .flags_o(flags_o),
    .bus_wr_o(bus_wr_o), .bus_rd_o(bus_rd_o), .bus_addr_o(bus_addr_o),
    .bus_rd_done_i(bus_rd_done_i));

//--- test/test_i2c_register_window.sv
/*
 * Bench of the I2C register window: bridged writes and reads, mailboxes,
 * pointer wraps, enables and flags. Assumes the master model and checker.
 */
`timescale 1ns/1ns
module test_i2c_register_window;
    localparam logic [6:0] TADDR = 7'h2a;
    logic        sys_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        rd_en_i = 1'b1;
    logic        wr_en_i = 1'b1;
    logic [2:0]  flag_clear_i = 3'b000;
    logic [2:0]  flag_enable_i = 3'b011;
    logic [31:0] bus_rdata_i = 32'h0000_0000;
    logic        bus_rd_done_i = 1'b0;
    logic        scl_rel, sda_rel, hung, ack;
    wire         scl_oe_n_o, sda_oe_n_o, irq_o, bus_wr_o, bus_rd_o;
    wire  [31:0] incoming_mailbox_o, bus_addr_o, bus_wdata_o;
    wire  [7:0]  pointer_view_field_o;
    wire  [2:0]  flags_o;
    wire         scl_w = scl_rel & scl_oe_n_o;
    wire         sda_w = sda_rel & sda_oe_n_o;
    int          err_count = 0;
    int          check_count = 0;
    int          rd_cnt = 0;
    int          rd_wait = 0;
    logic [31:0] rd_addr;
    logic [63:0] got;
    logic [63:0] wlog[$];

    always #5 sys_clk_i = ~sys_clk_i;

    i2c_register_window i2c_register_window_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl_w), .scl_o(),
        .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(), .sda_oe_n_o(sda_oe_n_o),
        .target_address_field_i(TADDR), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
        .flag_clear_i(flag_clear_i), .flag_enable_i(flag_enable_i),
        .outgoing_mailbox_i(32'h8765_4321), .status_summary_i(32'h0000_0001),
        .incoming_mailbox_o(incoming_mailbox_o), .pointer_view_field_o(pointer_view_field_o),
        .flags_o(flags_o), .irq_o(irq_o), .bus_wr_o(bus_wr_o), .bus_rd_o(bus_rd_o),
        .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i),
        .bus_rd_done_i(bus_rd_done_i));
    i2c_master_model #(.QUARTER(20)) i2c_master_model_i (.scl_w_i(scl_w), .sda_w_i(sda_w),
        .scl_rel_o(scl_rel), .sda_rel_o(sda_rel), .hung_o(hung));

    function automatic logic [31:0] rdm(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction
    // Internal bus: logs writes and answers reads late so that SCL gets stretched.
    always @(negedge sys_clk_i) begin
        bus_rd_done_i <= !bus_rd_o && rd_wait == 1;
        if (!bus_rd_o && rd_wait == 1)
            bus_rdata_i <= rdm(rd_addr);
        if (bus_wr_o)
            wlog.push_back({bus_addr_o, bus_wdata_o});
        if (bus_rd_o) begin
            rd_cnt++;
            rd_addr = bus_addr_o;
            rd_wait = 25;
        end else if (rd_wait > 0) begin
            rd_wait--;
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge hung) begin
        err_count++;
        $display("MISMATCH %0t SCL held low too long", $time);
        finish_test();
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic clr();
        flag_clear_i = 3'b111;
        repeat (2) @(negedge sys_clk_i);
        flag_clear_i = 3'b000;
        @(negedge sys_clk_i);
    endtask
    task automatic wr_tx(input logic [7:0] pa, input logic [63:0] d, input int n, input bit keep);
        logic a;
        i2c_master_model_i.start();
        i2c_master_model_i.wbyte({TADDR, 1'b0}, a);
        i2c_master_model_i.wbyte(pa, a);
        for (int i = 0; i < n; i++)
            i2c_master_model_i.wbyte(d[8*i +: 8], a);
        if (!keep)
            i2c_master_model_i.stop();
        chk(a, 1'b1, "write ack");
    endtask
    task automatic rd_tx(input int n, output logic [63:0] d);
        logic [7:0] b;
        logic       a;
        d = 64'h0;
        i2c_master_model_i.start();
        i2c_master_model_i.wbyte({TADDR, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            i2c_master_model_i.rbyte(b, i < n - 1);
            d[8*i +: 8] = b;
        end
        i2c_master_model_i.stop();
    endtask

    initial begin
        repeat (10) @(negedge sys_clk_i);
        reset_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        chk({pointer_view_field_o, flags_o, irq_o, sda_oe_n_o}, 13'h0001, "reset");
        i2c_master_model_i.start();
        i2c_master_model_i.wbyte({TADDR ^ 7'h01, 1'b0}, ack);
        i2c_master_model_i.stop();
        chk({ack, flags_o}, 4'h0, "foreign address");
        $display("test foreign_address done");
        wr_tx(8'h00, 64'h0004_9354, 4, 0);
        wr_tx(8'h04, 64'h5566_7788_1122_3344, 8, 0);
        chk(wlog.size(), 2, "write count");
        chk(wlog[0], 64'h0004_9354_1122_3344, "first write");
        chk(wlog[1], 64'h0004_9354_5566_7788, "second write");
        chk({pointer_view_field_o, flags_o, irq_o}, {8'h04, 4'b0111}, "after writes");
        clr();
        wr_en_i = 1'b0;
        wr_tx(8'h04, 64'haabb_ccdd, 4, 0);
        chk({wlog.size(), pointer_view_field_o}, {32'd2, 8'h04}, "write disabled");
        wr_en_i = 1'b1;
        $display("test bridged_write done");
        wr_tx(8'h90, 64'hcafe_f00d_1111_2222, 8, 0);
        chk({incoming_mailbox_o, pointer_view_field_o}, {32'hcafe_f00d, 8'h98}, "mbox");
        wr_tx(8'h90, 64'h0, 0, 0);
        rd_tx(8, got);
        chk(got, 64'hcafe_f00d_8765_4321, "mailbox read");
        wr_tx(8'hfe, 64'h5a5a, 2, 0);
        chk(pointer_view_field_o, 8'h00, "wrap at top");
        wr_tx(8'hfe, 64'h0, 0, 1);
        rd_tx(2, got);
        chk(got, 64'h0, "reserved reads zero");
        $display("test mailboxes done");
        clr();
        flag_enable_i = 3'b100;
        rd_cnt = 0;
        wr_tx(8'h10, 64'h0000_1237, 4, 1);
        rd_tx(8, got);
        chk(got, {2{rdm(32'h0000_1234)}}, "bridged reads");
        chk(rd_cnt, 2, "read count");
        chk({pointer_view_field_o, flags_o, irq_o}, {8'h14, 4'b1011}, "after reads");
        clr();
        rd_en_i = 1'b0;
        wr_tx(8'h14, 64'h0, 0, 1);
        rd_tx(1, got);
        chk({rd_cnt, flags_o, irq_o, got[7:0]}, {32'd2, 4'b0010, 8'h34}, "read disabled");
        rd_en_i = 1'b1;
        $display("test bridged_read done");
        wr_tx(8'h84, 64'h01, 1, 0);
        wr_tx(8'h20, 64'h0, 0, 1);
        rd_tx(1, got);
        chk({got[7:0], pointer_view_field_o}, 16'h0121, "alert byte");
        reset_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        reset_i = 1'b0;
        chk(pointer_view_field_o, 8'h00, "second reset");
        $display("test status_and_reset done");
        finish_test();
    end
endmodule
